/* shared/bulk_in_pkg.sv */
// Constants and carriers for the bulk-in frame packer
// Assumes one 200 MHz system clock domain
package bulk_in_pkg;
    localparam int          CLK_MHZ          = 200;
    localparam int          TERM_DELAY_US    = 34;
    localparam int          TERM_DELAY_CYC   = TERM_DELAY_US * CLK_MHZ;
    localparam logic [15:0] TERM_DELAY_RESET = 16'h0022;
    localparam logic [10:0] MPS_HS           = 11'h200;
    localparam logic [10:0] MPS_FS           = 11'h040;
    localparam logic [7:0]  CAP_MIN_HS       = 8'h04;
    localparam logic [7:0]  CAP_MIN_FS       = 8'h20;
    localparam int          LEN_W            = 14;
    localparam int          LEN_LSB          = 16;
    localparam int          CAP_HS_SHIFT     = 9;
    localparam int          CAP_FS_SHIFT     = 6;

    typedef enum logic [1:0] {
        RESP_NONE,
        RESP_DATA,
        RESP_ZLP,
        RESP_NAK
    } resp_e;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic        last;
    } word_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
        logic        last;
    } byte_s;
endpackage : bulk_in_pkg

/* verif/usb_bulk_in_frame_packer_tb.sv */
// Self-checking bench for the bulk-in frame packer
// Assumes the host model makes tokens; the bench models the receive FIFO
`timescale 1ns/1ps
`default_nettype none
module usb_bulk_in_frame_packer_tb;
    import bulk_in_pkg::*;
    logic        clk;
    logic        rstn;
    logic        multi_frame_packing;
    logic        high_speed;
    logic        burst_limit_enable;
    logic [7:0]  burst_limit;
    logic        empty_response_select;
    logic [15:0] burst_termination_delay;
    word_s       fifo_word;
    logic [15:0] fifo_level;
    logic        in_token;
    logic        host_ack;
    logic        host_timeout;
    logic        fifo_pop;
    logic        fifo_rewind;
    logic        fifo_advance;
    resp_e       resp;
    byte_s       tx_byte;
    logic        ep_stall;
    logic        timer_running;
    int          bad_count = 0;
    int          total_checks = 0;
    int          rd = 0;
    int          base = 0;
    int          rewinds = 0;
    int          advances = 0;
    logic [15:0] lfsr = 16'h002E;
    word_s       mem[$];
    logic [7:0]  exp_q[$];
    usb_bulk_in_frame_packer u_dut (
        .clk(clk), .rstn(rstn), .multi_frame_packing(multi_frame_packing),
        .high_speed(high_speed), .burst_limit_enable(burst_limit_enable),
        .burst_limit(burst_limit), .empty_response_select(empty_response_select),
        .burst_termination_delay(burst_termination_delay), .fifo_word(fifo_word),
        .fifo_level(fifo_level), .in_token(in_token), .host_ack(host_ack),
        .host_timeout(host_timeout), .fifo_pop(fifo_pop), .fifo_rewind(fifo_rewind),
        .fifo_advance(fifo_advance), .resp(resp), .tx_byte(tx_byte),
        .ep_stall(ep_stall), .timer_running(timer_running)
    );
    usb_host_model u_host (
        .clk(clk), .resp(resp), .tx_byte(tx_byte), .in_token(in_token),
        .host_ack(host_ack), .host_timeout(host_timeout)
    );
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic final_report();
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // Status word, frame words, expected byte stream
    task automatic add_frame(input int len, input logic pad);
        logic [31:0] w;
        w = {2'b00, 14'(len), rnd()};
        mem.push_back('{1'b1, w, 1'b0});
        for (int b = 0; b < 4; b++) exp_q.push_back(w[8*b +: 8]);
        for (int k = 0; k < len; k += 4) begin
            w = {rnd(), rnd()};
            mem.push_back('{1'b1, w, (k + 4 >= len)});
            for (int b = 0; b < 4 && k + b < len; b++) exp_q.push_back(w[8*b +: 8]);
        end
        if (pad) while (exp_q.size() % 4 != 0) exp_q.push_back(8'h00);
    endtask : add_frame
    task automatic xfer(input logic ack, input resp_e er, input int n);
        resp_e got;
        logic  ok;
        u_host.transfer(ack, got, ok);
        if (!ok) begin
            bad_count++;
            $display("CHECK FAILED host wait expected 1 seen 0");
            final_report();
        end
        check("resp", 32'(er), 32'(got));
        check("byte count", 32'(n), 32'(u_host.rx_q.size()));
        for (int i = 0; i < n && i < u_host.rx_q.size(); i++) begin
            check("byte", 32'(exp_q[i]), 32'(u_host.rx_q[i]));
        end
        if (ack) repeat (n) void'(exp_q.pop_front());
    endtask : xfer
    // FIFO controller model: pop, rewind, advance on ack
    always @(negedge clk) begin
        if (fifo_rewind) rd = base;
        else if (fifo_pop && rd < mem.size()) rd++;
        if (fifo_rewind) rewinds++;
        if (fifo_advance) base = rd;
        if (fifo_advance) advances++;
        fifo_word  = (rd < mem.size()) ? mem[rd] : '{1'b0, ~fifo_word.data, 1'b0};
        fifo_level = 16'((mem.size() - rd) * 4);
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        logic [10:0] cases[4];
        resp_e       cresp[4];
        int          l1;
        int          l2;
        cases = '{11'h400, 11'h401, 11'h609, 11'h241};
        cresp = '{RESP_ZLP, RESP_NAK, RESP_NAK, RESP_NAK};
        rstn = 1'b0;
        multi_frame_packing = 1'b0;
        high_speed = 1'b1;
        burst_limit_enable = 1'b0;
        burst_limit = 8'h00;
        empty_response_select = 1'b0;
        burst_termination_delay = TERM_DELAY_RESET;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        check("stall", 32'h0, 32'(ep_stall));
        for (int i = 0; i < 4; i++) begin
            {high_speed, burst_limit_enable, burst_limit, empty_response_select} = cases[i];
            xfer(1'b1, cresp[i], 0);
        end
        $display("Test empty tokens done");
        {high_speed, burst_limit_enable, burst_limit, empty_response_select} = 11'h400;
        for (int i = 0; i < 3; i++) begin
            l1 = 1 + int'(rnd() % 200);
            add_frame(l1, 1'b0);
            repeat (4) @(negedge clk);
            xfer(1'b1, RESP_DATA, l1 + 4);
        end
        $display("Test single frame done");
        l1 = 1 + int'(rnd() % 200);
        add_frame(l1, 1'b0);
        repeat (4) @(negedge clk);
        xfer(1'b0, RESP_DATA, l1 + 4);
        repeat (2) @(negedge clk);
        check("rewinds", 32'd1, 32'(rewinds));
        l2 = advances;
        xfer(1'b1, RESP_DATA, l1 + 4);
        repeat (2) @(negedge clk);
        check("advances", 32'(l2 + 1), 32'(advances));
        $display("Test resend done");
        high_speed = 1'b0;
        add_frame(124, 1'b0);
        repeat (4) @(negedge clk);
        xfer(1'b1, RESP_DATA, 64);
        xfer(1'b1, RESP_DATA, 64);
        xfer(1'b1, RESP_ZLP, 0);
        high_speed = 1'b1;
        $display("Test exact multiple done");
        multi_frame_packing = 1'b1;
        burst_termination_delay = 16'h0001;
        l1 = 1 + int'(rnd() % 200);
        add_frame(l1, 1'b0);
        repeat (4) @(negedge clk);
        check("timer", 32'h1, 32'(timer_running));
        xfer(1'b1, RESP_NAK, 0);
        repeat (220) @(negedge clk);
        check("timer", 32'h0, 32'(timer_running));
        xfer(1'b1, RESP_DATA, l1 + 4);
        $display("Test delay done");
        burst_termination_delay = 16'h0000;
        l1 = 1 + 2 * int'(rnd() % 100);
        l2 = 1 + int'(rnd() % 200);
        add_frame(l1, 1'b1);
        add_frame(l2, 1'b0);
        repeat (4) @(negedge clk);
        xfer(1'b1, RESP_DATA, exp_q.size());
        $display("Test multi frame done");
        final_report();
    end
endmodule : usb_bulk_in_frame_packer_tb
`default_nettype wire

/* verif/usb_host_model.sv */
// Host side model: issues IN tokens, gathers packet bytes, acks or misses
// Assumes its outputs change at falling edges of the design clock
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
    import bulk_in_pkg::*;
(
    input  wire logic  clk,
    input  wire resp_e resp,
    input  wire byte_s tx_byte,
    output logic       in_token,
    output logic       host_ack,
    output logic       host_timeout
);
    logic [7:0] rx_q[$];
    initial begin
        in_token     = 1'b0;
        host_ack     = 1'b0;
        host_timeout = 1'b0;
    end
    // Token, then gather until the answer ends
    task automatic transfer(input logic ack, output resp_e got, output logic ok);
        logic done;
        got  = RESP_NONE;
        done = 1'b0;
        rx_q.delete();
        @(negedge clk);
        in_token = 1'b1;
        @(negedge clk);
        in_token = 1'b0;
        for (int i = 0; i < 2000 && !done; i++) begin
            if (got == RESP_NONE) got = resp;
            if (tx_byte.valid) rx_q.push_back(tx_byte.data);
            done = (got inside {RESP_ZLP, RESP_NAK}) || (tx_byte.valid && tx_byte.last);
            if (!done) @(negedge clk);
        end
        ok = done;
        if (done && got != RESP_NAK) begin
            host_ack     = ack;
            host_timeout = !ack;
            @(negedge clk);
            host_ack     = 1'b0;
            host_timeout = 1'b0;
        end
    endtask : transfer
endmodule : usb_host_model
`default_nettype wire

/* verilog/term_delay_timer.sv */
// Restartable termination delay timer counted in microseconds
// Assumes start is a single-cycle pulse and clear may be held high, both in the clk domain
`timescale 1ns/1ps
`default_nettype none
module term_delay_timer
    import bulk_in_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic        clear,
    input  wire logic [15:0] delay_us,
    output logic             running
);
    logic [7:0]  cyc;
    logic [15:0] us;
    logic [7:0]  next_cyc;
    logic [15:0] next_us;
    logic        next_running;

    always_comb begin
        next_cyc     = cyc;
        next_us      = us;
        next_running = running;
        if (clear) begin
            next_running = 1'b0;
        end else if (start) begin
            next_running = (delay_us != 16'h0000);
            next_cyc     = 8'h00;
            next_us      = 16'h0000;
        end else if (running) begin
            if (cyc == 8'(CLK_MHZ - 1)) begin
                next_cyc = 8'h00;
                next_us  = us + 16'h0001;
                if (us + 16'h0001 >= delay_us) begin
                    next_running = 1'b0;
                end
            end else begin
                next_cyc = cyc + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cyc     <= 8'h00;
            us      <= 16'h0000;
            running <= 1'b0;
        end else begin
            cyc     <= next_cyc;
            us      <= next_us;
            running <= next_running;
        end
    end

    a_timer_bounded: assert property (@(posedge clk) disable iff (!rstn)
        (start && !clear && delay_us == 16'h0001) |=> running [*8])
        else $error("timer stopped early");
endmodule : term_delay_timer
`default_nettype wire

/* verilog/usb_bulk_in_frame_packer.sv */
// Bulk-in endpoint packer: FIFO words in, packet bytes out per IN token
// Assumes the protocol engine handles PID, toggle and CRC; FIFO sends status first
`timescale 1ns/1ps
`default_nettype none
module usb_bulk_in_frame_packer
    import bulk_in_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        multi_frame_packing,
    input  wire logic        high_speed,
    input  wire logic        burst_limit_enable,
    input  wire logic [7:0]  burst_limit,
    input  wire logic        empty_response_select,
    input  wire logic [15:0] burst_termination_delay,
    input  wire word_s       fifo_word,
    input  wire logic [15:0] fifo_level,
    input  wire logic        in_token,
    input  wire logic        host_ack,
    input  wire logic        host_timeout,
    output logic             fifo_pop,
    output logic             fifo_rewind,
    output logic             fifo_advance,
    output resp_e            resp,
    output byte_s            tx_byte,
    output logic             ep_stall,
    output logic             timer_running
);
    typedef enum logic [2:0] {
        IDLE,
        HDR,
        SEND,
        PAD,
        WAIT_ACK
    } st_e;

    st_e          st, next_st;
    logic [31:0]  cur, next_cur;
    logic [1:0]   bsel, next_bsel;
    logic [LEN_W-1:0] frame_left, next_frame_left;
    logic [LEN_W-1:0] pkt_left, next_pkt_left;
    logic         was_empty;
    logic [10:0]  pkt_cnt, next_pkt_cnt;
    logic [22:0]  burst_cnt, next_burst_cnt;
    logic         term_pend, next_term_pend;
    logic         is_term, next_is_term;
    logic         fifo_pop_n, rewind_n, adv_n;
    resp_e        resp_n;
    byte_s        tx_n;
    logic         tmr_start, tmr_clear;
    logic [10:0]  mps;
    logic         cap_on;
    logic [22:0]  cap_bytes;
    logic         fifo_empty;

    assign mps = high_speed ? MPS_HS : MPS_FS;
    assign cap_on = burst_limit_enable &&
        (high_speed ? (burst_limit > CAP_MIN_HS) : (burst_limit > CAP_MIN_FS));
    assign cap_bytes = high_speed ? (23'(burst_limit) << CAP_HS_SHIFT)
                                  : (23'(burst_limit) << CAP_FS_SHIFT);
    assign fifo_empty = (fifo_level == 16'h0000);

    term_delay_timer u_timer (
        .clk      (clk),
        .rstn     (rstn),
        .start    (tmr_start),
        .clear    (tmr_clear),
        .delay_us (burst_termination_delay),
        .running  (timer_running)
    );

    always_comb begin
        next_st         = st;
        next_cur        = cur;
        next_bsel       = bsel;
        next_frame_left = frame_left;
        next_pkt_left   = pkt_left;
        next_pkt_cnt    = pkt_cnt;
        next_burst_cnt  = burst_cnt;
        next_term_pend  = term_pend;
        next_is_term    = is_term;
        fifo_pop_n      = 1'b0;
        rewind_n        = 1'b0;
        adv_n           = 1'b0;
        resp_n          = RESP_NONE;
        tx_n            = '0;
        tmr_start       = 1'b0;
        tmr_clear       = 1'b0;
        case (st)
            IDLE: begin
                if (in_token) begin
                    next_pkt_cnt = 11'h000;
                    if (timer_running && multi_frame_packing) begin
                        resp_n = RESP_NAK;
                    end else if (term_pend || fifo_empty ||
                                 (cap_on && burst_cnt >= cap_bytes)) begin
                        if (!term_pend && fifo_empty && !cap_on &&
                            empty_response_select) begin
                            resp_n = RESP_NAK;
                        end else begin
                            resp_n       = RESP_ZLP;
                            next_is_term = 1'b1;
                            next_st      = WAIT_ACK;
                        end
                    end else begin
                        resp_n       = RESP_DATA;
                        next_is_term = 1'b0;
                        next_pkt_left = frame_left;
                        next_st      = (frame_left == '0) ? HDR : SEND;
                    end
                end
            end
            HDR: begin
                if (fifo_word.valid) begin
                    fifo_pop_n      = 1'b1;
                    next_cur        = fifo_word.data;
                    // Count also covers the three status bytes still to go
                    next_frame_left = fifo_word.data[LEN_LSB +: LEN_W] + LEN_W'(3);
                    // offset pad is already in FIFO data
                    tx_n.valid      = 1'b1;
                    tx_n.data       = fifo_word.data[7:0];
                    next_bsel       = 2'd1;
                    next_pkt_cnt    = pkt_cnt + 11'h001;
                    next_st         = SEND;
                end
            end
            SEND: begin
                if (bsel == 2'd0 && !fifo_word.valid) begin
                    next_st = SEND;
                end else begin
                    tx_n.valid   = 1'b1;
                    tx_n.data    = (bsel == 2'd0) ? fifo_word.data[7:0]
                                                  : cur[8*bsel +: 8];
                    if (bsel == 2'd0) begin
                        next_cur   = fifo_word.data;
                        fifo_pop_n = 1'b1;
                    end
                    next_bsel    = bsel + 2'd1;
                    next_pkt_cnt = pkt_cnt + 11'h001;
                    if (frame_left != '0) begin
                        next_frame_left = frame_left - 1'b1;
                    end
                    if (pkt_cnt + 11'h001 == mps) begin
                        tx_n.last = 1'b1;
                        next_st   = WAIT_ACK;
                    end else if (frame_left == LEN_W'(1)) begin
                        // pad not in length
                        // Word being popped now still shows in the level
                        if (multi_frame_packing &&
                            ((bsel == 2'd0) ? (fifo_level > 16'h0004) : !fifo_empty) &&
                            !(cap_on && burst_cnt + 23'(pkt_cnt) >= cap_bytes)) begin
                            next_st = (bsel == 2'd3) ? HDR : PAD;
                        end else begin
                            tx_n.last    = 1'b1;
                            next_is_term = 1'b1;
                            next_st      = WAIT_ACK;
                        end
                    end
                end
            end
            PAD: begin
                tx_n.valid   = 1'b1;
                next_bsel    = bsel + 2'd1;
                next_pkt_cnt = pkt_cnt + 11'h001;
                if (pkt_cnt + 11'h001 == mps) begin
                    tx_n.last = 1'b1;
                    next_st   = WAIT_ACK;
                end else if (bsel == 2'd3) begin
                    next_st = HDR;
                end
            end
            WAIT_ACK: begin
                if (host_ack) begin
                    adv_n          = 1'b1;
                    next_burst_cnt = burst_cnt + 23'(pkt_cnt);
                    next_term_pend = !is_term && (pkt_cnt == mps) && (frame_left == '0) &&
                                     (fifo_empty || !multi_frame_packing);
                    if (is_term) begin
                        next_burst_cnt = 23'h000000;
                        next_term_pend = 1'b0;
                    end
                    if (multi_frame_packing && !is_term) begin
                        tmr_start = 1'b1;
                    end
                    next_st = IDLE;
                end else if (host_timeout) begin
                    rewind_n = 1'b1;
                    // Zero-length terminator repeats; data is rewound and resent
                    if (is_term && pkt_cnt == 11'h000) begin
                        next_term_pend = 1'b1;
                    end
                    next_frame_left = pkt_left;
                    next_bsel       = 2'd0;
                    next_st         = IDLE;
                end
            end
            default: next_st = IDLE;
        endcase
        if (multi_frame_packing && st == IDLE && was_empty && !fifo_empty &&
            fifo_level < 16'(mps)) begin
            tmr_start = 1'b1;
        end
        if (!multi_frame_packing) begin
            tmr_clear = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st           <= IDLE;
            cur          <= 32'h00000000;
            bsel         <= 2'd0;
            frame_left   <= '0;
            pkt_cnt      <= 11'h000;
            burst_cnt    <= 23'h000000;
            term_pend    <= 1'b0;
            is_term      <= 1'b0;
            pkt_left     <= '0;
            was_empty    <= 1'b1;
            fifo_pop     <= 1'b0;
            fifo_rewind  <= 1'b0;
            fifo_advance <= 1'b0;
            resp         <= RESP_NONE;
            tx_byte      <= '0;
            ep_stall     <= 1'b0;
        end else begin
            st           <= next_st;
            cur          <= next_cur;
            bsel         <= next_bsel;
            frame_left   <= next_frame_left;
            pkt_cnt      <= next_pkt_cnt;
            burst_cnt    <= next_burst_cnt;
            term_pend    <= next_term_pend;
            is_term      <= next_is_term;
            pkt_left     <= next_pkt_left;
            was_empty    <= fifo_empty;
            fifo_pop     <= fifo_pop_n;
            fifo_rewind  <= rewind_n;
            fifo_advance <= adv_n;
            resp         <= resp_n;
            tx_byte      <= tx_n;
            ep_stall     <= 1'b0;
        end
    end

    a_never_stall: assert property (@(posedge clk) disable iff (!rstn)
        !ep_stall)
        else $error("endpoint stalled");
    a_nak_in_delay: assert property (@(posedge clk) disable iff (!rstn)
        (in_token && st == IDLE && timer_running && multi_frame_packing)
        |=> resp == RESP_NAK)
        else $error("token not NAKed during delay");
    a_ack_advance: assert property (@(posedge clk) disable iff (!rstn)
        (st == WAIT_ACK && host_ack) |=> fifo_advance && !fifo_rewind)
        else $error("ack did not advance");
    a_miss_rewind: assert property (@(posedge clk) disable iff (!rstn)
        (st == WAIT_ACK && !host_ack && host_timeout) |=> fifo_rewind)
        else $error("miss did not rewind");
    a_term_repeat: assert property (@(posedge clk) disable iff (!rstn)
        (st == WAIT_ACK && is_term && !host_ack && host_timeout)
        ##1 (in_token && !(timer_running && multi_frame_packing))
        |=> resp == (($past(pkt_cnt, 2) == 11'h000) ? RESP_ZLP : RESP_DATA))
        else $error("terminator not repeated");
    a_empty_zlp: assert property (@(posedge clk) disable iff (!rstn)
        (st == IDLE && in_token && fifo_empty && !term_pend && !cap_on &&
         !empty_response_select && !(timer_running && multi_frame_packing))
        |=> resp == RESP_ZLP)
        else $error("empty token not ZLP");
    a_empty_nak: assert property (@(posedge clk) disable iff (!rstn)
        (st == IDLE && in_token && fifo_empty && !term_pend && !cap_on &&
         empty_response_select && !(timer_running && multi_frame_packing))
        |=> resp == RESP_NAK)
        else $error("empty token not NAK");
    a_pkt_size: assert property (@(posedge clk) disable iff (!rstn)
        tx_byte.valid |-> pkt_cnt <= mps)
        else $error("packet over max size");
    a_sef_timer: assert property (@(posedge clk) disable iff (!rstn)
        !multi_frame_packing |=> !timer_running)
        else $error("timer runs in single mode");

    c_data_pkt: cover property (@(posedge clk) resp == RESP_DATA);
    c_zlp: cover property (@(posedge clk) resp == RESP_ZLP);
    c_rewind: cover property (@(posedge clk) fifo_rewind);
    c_nak_delay: cover property (@(posedge clk) timer_running && resp == RESP_NAK);
endmodule : usb_bulk_in_frame_packer
`default_nettype wire
